// ---- hdl/qset_pkg.sv ----
// Constants shared by the questionable status event tree
package qset_pkg;
    localparam int          QSET_W        = 15;
    localparam int          QSET_STB_W    = 8;
    localparam int          QSET_DW       = 32;
    localparam int          QSET_AW       = 8;
    localparam logic [14:0] QSET_RISE_RST = 15'h7FFF;
    localparam logic [14:0] QSET_FALL_RST = 15'h0000;
    localparam logic [14:0] QSET_EN_RST   = 15'h0000;
    localparam logic [14:0] QSET_ZERO     = 15'h0000;
    localparam int          QSET_CAL_BIT  = 8;
    localparam int          QSET_TEMP_BIT = 4;
    localparam int          QSET_ALIGN_BIT = 14;
    localparam int          QSET_SB_QUES  = 3;
    localparam int          QSET_SB_OPER  = 7;
    localparam int          QSET_LO_MSB   = 7;
    // Byte address is {group, field}
    localparam logic [2:0]  QSET_G_QUES   = 3'h0;
    localparam logic [2:0]  QSET_G_CAL    = 3'h1;
    localparam logic [2:0]  QSET_G_OPER   = 3'h2;
    localparam logic [2:0]  QSET_G_MISC   = 3'h3;
    localparam logic [4:0]  QSET_F_COND   = 5'h00;
    localparam logic [4:0]  QSET_F_EVENT  = 5'h04;
    localparam logic [4:0]  QSET_F_EN     = 5'h08;
    localparam logic [4:0]  QSET_F_RISE   = 5'h0C;
    localparam logic [4:0]  QSET_F_FALL   = 5'h10;
    localparam logic [4:0]  QSET_F_STB    = 5'h00;
    localparam logic [4:0]  QSET_F_PRESET = 5'h04;
endpackage

// ---- hdl/qset_stage_if.sv ----
// Link between the bus front end and one event stage
`timescale 1ns/1ps
interface qset_stage_if;
    import qset_pkg::*;
    logic [QSET_W-1:0] cond;
    logic [QSET_W-1:0] wdata;
    logic [1:0]        wsel;
    logic              wr_en;
    logic              wr_rise;
    logic              wr_fall;
    logic              preset;
    logic              rd_clr;
    logic [QSET_W-1:0] event_q;
    logic [QSET_W-1:0] en_q;
    logic [QSET_W-1:0] rise_q;
    logic [QSET_W-1:0] fall_q;
    logic              summary;
    modport ctrl  (output cond, wdata, wsel, wr_en, wr_rise, wr_fall, preset, rd_clr,
                   input event_q, en_q, rise_q, fall_q, summary);
    modport stage (input cond, wdata, wsel, wr_en, wr_rise, wr_fall, preset, rd_clr,
                   output event_q, en_q, rise_q, fall_q, summary);
endinterface

// ---- hdl/qset_stage.sv ----
// One stage: transition filters, latched events, enable mask, summary
`timescale 1ns/1ps
module qset_stage
    import qset_pkg::*;
(
    // Clock and reset
    input wire logic   clk,
    input wire logic   rst_n,
    // Front end link
    qset_stage_if.stage sif
);
    typedef struct packed {
        logic [QSET_W-1:0] prev;
        logic [QSET_W-1:0] event_r;
        logic [QSET_W-1:0] en;
        logic [QSET_W-1:0] rise;
        logic [QSET_W-1:0] fall;
    } qset_stage_type;

    qset_stage_type    s_q;
    qset_stage_type    s_d;
    logic [QSET_W-1:0] rise_ev;
    logic [QSET_W-1:0] fall_ev;

    function automatic logic [QSET_W-1:0] qset_merge(input logic [QSET_W-1:0] old,
                                                     input logic [QSET_W-1:0] nw,
                                                     input logic [1:0] sel);
        qset_merge = old;
        if (sel[0])
        begin
            qset_merge[QSET_LO_MSB:0] = nw[QSET_LO_MSB:0];
        end
        if (sel[1])
        begin
            qset_merge[QSET_W-1:QSET_LO_MSB+1] = nw[QSET_W-1:QSET_LO_MSB+1];
        end
    endfunction

    assign rise_ev = sif.cond & ~s_q.prev & s_q.rise;
    assign fall_ev = ~sif.cond & s_q.prev & s_q.fall;

    always_comb
    begin
        s_d = s_q;
        s_d.prev = sif.cond;
        // sticky, set wins over read clear
        s_d.event_r = (sif.rd_clr ? QSET_ZERO : s_q.event_r) | rise_ev | fall_ev;
        if (sif.preset)
        begin
            s_d.en   = QSET_EN_RST;
            s_d.rise = QSET_RISE_RST;
            s_d.fall = QSET_FALL_RST;
        end
        if (sif.wr_en)
        begin
            s_d.en = qset_merge(s_q.en, sif.wdata, sif.wsel);
        end
        if (sif.wr_rise)
        begin
            s_d.rise = qset_merge(s_q.rise, sif.wdata, sif.wsel);
        end
        if (sif.wr_fall)
        begin
            s_d.fall = qset_merge(s_q.fall, sif.wdata, sif.wsel);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q <= '{prev: QSET_ZERO, event_r: QSET_ZERO, en: QSET_EN_RST,
                     rise: QSET_RISE_RST, fall: QSET_FALL_RST};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sif.event_q = s_q.event_r;
    assign sif.en_q    = s_q.en;
    assign sif.rise_q  = s_q.rise;
    assign sif.fall_q  = s_q.fall;
    assign sif.summary = |(s_q.event_r & s_q.en);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_sticky;
        !sif.rd_clr |=> ((s_q.event_r & $past(s_q.event_r)) == $past(s_q.event_r));
    endproperty
    a_sticky: assert property (p_sticky) else $error("event bit lost without read");

    property p_no_filter;
        (s_q.rise == QSET_ZERO && s_q.fall == QSET_ZERO && s_q.event_r == QSET_ZERO && !sif.preset)
            |=> s_q.event_r == QSET_ZERO;
    endproperty
    a_no_filter: assert property (p_no_filter) else $error("event set with filters clear");

    property p_fall;
        (fall_ev != QSET_ZERO) |=> ((s_q.event_r & $past(fall_ev)) == $past(fall_ev));
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge not latched");

    property p_rise;
        (rise_ev != QSET_ZERO) |=> ((s_q.event_r & $past(rise_ev)) == $past(rise_ev));
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge not latched");

    property p_preset;
        (sif.preset && !sif.wr_en && !sif.wr_rise && !sif.wr_fall)
            |=> (s_q.rise == QSET_RISE_RST && s_q.fall == QSET_FALL_RST && s_q.en == QSET_EN_RST);
    endproperty
    a_preset: assert property (p_preset) else $error("preset missed a mask");

    c_rise: cover property (rise_ev != QSET_ZERO);
    c_fall: cover property (fall_ev != QSET_ZERO);
endmodule

// ---- hdl/qset_top.sv ----
// Questionable status event tree with classic Wishbone register slave
//
// Contract
// - Enable mask 16 passes temperature summary event to status byte summary.
// - Event bits stay latched until read; a read returns then clears them.
// - Condition sets event only through a set rise or fall filter bit.
// - Event read returns all bits as one unsigned binary-weighted integer.
// - Falling condition with fall filter bit sets event; fall filter resets zero.
// - Rising condition with rise filter bit sets event; rise filter resets ones.
// - Fall filter 16 records temperature summary clearing, reaching status byte.
// - Rise filter 16 records temperature summary asserting.
// - Condition registers do not latch; reads return live state.
// - Calibration condition read returns live bits as binary-weighted integer.
// - Enabled calibration events drive calibration summary at questionable bit 8.
// - Calibration bit 16384 flags alignment needed, visible when enabled.
// - Operation rise filter 1 reports align-now start to status byte.
// - Questionable summary is status byte bit 3.
// - Preset restores filters and enables, leaving events untouched.
`timescale 1ns/1ps
module qset_top
    import qset_pkg::*;
(
    // Clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  RESET_N,
    // Wishbone slave
    input  wire logic                  CYC_I,
    input  wire logic                  STB_I,
    input  wire logic                  WE_I,
    input  wire logic [QSET_AW-1:0]    ADR_I,
    input  wire logic [3:0]            SEL_I,
    input  wire logic [QSET_DW-1:0]    DAT_I,
    output      logic [QSET_DW-1:0]    DAT_O,
    output      logic                  ACK_O,
    // Live condition pins
    input  wire logic [QSET_W-1:0]     QUES_COND,
    input  wire logic [QSET_W-1:0]     CAL_COND,
    input  wire logic [QSET_W-1:0]     OPER_COND,
    // Status byte
    output      logic [QSET_STB_W-1:0] STATUS_BYTE
);
    localparam int PW = 3 * QSET_W;
    // Field offset bits inside a group
    localparam int FLD_W = $bits(QSET_F_COND);
    // Status byte bits that carry a summary
    localparam logic [QSET_STB_W-1:0] SB_USED = (QSET_STB_W'(1) << QSET_SB_QUES) | (QSET_STB_W'(1) << QSET_SB_OPER);

    typedef struct packed {
        logic [PW-1:0]         sync1;
        logic [PW-1:0]         sync2;
        logic [PW-1:0]         sync3;
        logic [PW-1:0]         filt;
        logic                  ack;
        logic [QSET_DW-1:0]    dat;
        logic [QSET_STB_W-1:0] sb;
        logic                  q8_prev;
    } qset_top_type;

    qset_top_type          m_q;
    qset_top_type          m_d;
    logic                  req;
    logic                  wr;
    logic                  rd;
    logic [2:0]            grp;
    logic [4:0]            fld;
    logic [QSET_W-1:0]     ques_live;
    logic [QSET_W-1:0]     cal_live;
    logic [QSET_W-1:0]     oper_live;
    logic [QSET_W-1:0]     rd_val;

    qset_stage_if q_sif();
    qset_stage_if c_sif();
    qset_stage_if o_sif();

    // Field read of one stage
    function automatic logic [QSET_W-1:0] qset_rd(input logic [4:0] f,
                                                  input logic [QSET_W-1:0] cond,
                                                  input logic [QSET_W-1:0] ev,
                                                  input logic [QSET_W-1:0] en,
                                                  input logic [QSET_W-1:0] ri,
                                                  input logic [QSET_W-1:0] fa);
        case (f)
            QSET_F_COND:  qset_rd = cond;
            QSET_F_EVENT: qset_rd = ev;
            QSET_F_EN:    qset_rd = en;
            QSET_F_RISE:  qset_rd = ri;
            QSET_F_FALL:  qset_rd = fa;
            default:      qset_rd = QSET_ZERO;
        endcase
    endfunction

    // Address hit for one field of one group
    function automatic logic qset_hit(input logic [2:0] g, input logic [4:0] f,
                                      input logic [2:0] gw, input logic [4:0] fw);
        qset_hit = (g == gw) && (f == fw);
    endfunction

    assign req = CYC_I & STB_I & ~m_q.ack;
    assign wr  = req & WE_I;
    assign rd  = req & ~WE_I;
    assign grp = ADR_I[QSET_AW-1:FLD_W];
    assign fld = ADR_I[FLD_W-1:0];

    assign oper_live = m_q.filt[3*QSET_W-1:2*QSET_W];
    assign cal_live  = m_q.filt[2*QSET_W-1:QSET_W];
    always_comb
    begin
        ques_live = m_q.filt[QSET_W-1:0];
        ques_live[QSET_CAL_BIT] = c_sif.summary;
    end

    assign q_sif.cond = ques_live;
    assign c_sif.cond = cal_live;
    assign o_sif.cond = oper_live;

    assign q_sif.wdata = DAT_I[QSET_W-1:0];
    assign c_sif.wdata = DAT_I[QSET_W-1:0];
    assign o_sif.wdata = DAT_I[QSET_W-1:0];
    assign q_sif.wsel  = SEL_I[1:0];
    assign c_sif.wsel  = SEL_I[1:0];
    assign o_sif.wsel  = SEL_I[1:0];

    assign q_sif.wr_en   = wr & qset_hit(grp, fld, QSET_G_QUES, QSET_F_EN);
    assign q_sif.wr_rise = wr & qset_hit(grp, fld, QSET_G_QUES, QSET_F_RISE);
    assign q_sif.wr_fall = wr & qset_hit(grp, fld, QSET_G_QUES, QSET_F_FALL);
    assign c_sif.wr_en   = wr & qset_hit(grp, fld, QSET_G_CAL, QSET_F_EN);
    assign c_sif.wr_rise = wr & qset_hit(grp, fld, QSET_G_CAL, QSET_F_RISE);
    assign c_sif.wr_fall = wr & qset_hit(grp, fld, QSET_G_CAL, QSET_F_FALL);
    assign o_sif.wr_en   = wr & qset_hit(grp, fld, QSET_G_OPER, QSET_F_EN);
    assign o_sif.wr_rise = wr & qset_hit(grp, fld, QSET_G_OPER, QSET_F_RISE);
    assign o_sif.wr_fall = wr & qset_hit(grp, fld, QSET_G_OPER, QSET_F_FALL);

    assign q_sif.preset = wr & qset_hit(grp, fld, QSET_G_MISC, QSET_F_PRESET);
    assign c_sif.preset = q_sif.preset;
    assign o_sif.preset = q_sif.preset;

    // clear on read of event register
    assign q_sif.rd_clr = rd & qset_hit(grp, fld, QSET_G_QUES, QSET_F_EVENT);
    assign c_sif.rd_clr = rd & qset_hit(grp, fld, QSET_G_CAL, QSET_F_EVENT);
    assign o_sif.rd_clr = rd & qset_hit(grp, fld, QSET_G_OPER, QSET_F_EVENT);

    // read value as plain binary integer
    always_comb
    begin
        case (grp)
            QSET_G_QUES: rd_val = qset_rd(fld, ques_live, q_sif.event_q, q_sif.en_q,
                                          q_sif.rise_q, q_sif.fall_q);
            QSET_G_CAL:  rd_val = qset_rd(fld, cal_live, c_sif.event_q, c_sif.en_q,
                                          c_sif.rise_q, c_sif.fall_q);
            QSET_G_OPER: rd_val = qset_rd(fld, oper_live, o_sif.event_q, o_sif.en_q,
                                          o_sif.rise_q, o_sif.fall_q);
            QSET_G_MISC: rd_val = (fld == QSET_F_STB) ? {7'h00, m_q.sb} : QSET_ZERO;
            default:     rd_val = QSET_ZERO;
        endcase
    end

    always_comb
    begin
        m_d = m_q;
        // Pin filter: a bit moves once stages two and three agree
        m_d.sync1 = {OPER_COND, CAL_COND, QUES_COND};
        m_d.sync2 = m_q.sync1;
        m_d.sync3 = m_q.sync2;
        m_d.filt  = (m_q.sync3 & ~(m_q.sync2 ^ m_q.sync3)) | (m_q.filt & (m_q.sync2 ^ m_q.sync3));
        m_d.ack   = req;
        if (rd)
        begin
            m_d.dat = {17'h00000, rd_val};
        end
        m_d.sb = '0;
        m_d.sb[QSET_SB_QUES] = q_sif.summary;
        m_d.sb[QSET_SB_OPER] = o_sif.summary;
        m_d.q8_prev = ques_live[QSET_CAL_BIT];
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            m_q <= '0;
        end
        else
        begin
            m_q <= m_d;
        end
    end

    assign ACK_O       = m_q.ack;
    assign DAT_O       = m_q.dat;
    assign STATUS_BYTE = m_q.sb;

    qset_stage u_ques
    (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .sif   (q_sif)
    );

    qset_stage u_cal
    (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .sif   (c_sif)
    );

    qset_stage u_oper
    (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .sif   (o_sif)
    );

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    property p_temp_pass;
        (q_sif.en_q[QSET_TEMP_BIT] && q_sif.event_q[QSET_TEMP_BIT]) |=> STATUS_BYTE[QSET_SB_QUES];
    endproperty
    a_temp_pass: assert property (p_temp_pass) else $error("temperature event not summarised");

    property p_summary;
        (q_sif.event_q & q_sif.en_q) == QSET_ZERO |=> !STATUS_BYTE[QSET_SB_QUES];
    endproperty
    a_summary: assert property (p_summary) else $error("summary set with nothing enabled");

    property p_cond_live;
        (rd && grp == QSET_G_CAL && fld == QSET_F_COND)
            |=> ACK_O && DAT_O[QSET_W-1:0] == $past(cal_live);
    endproperty
    a_cond_live: assert property (p_cond_live) else $error("condition read not live");

    property p_event_read;
        q_sif.rd_clr |=> ACK_O && DAT_O[QSET_W-1:0] == $past(q_sif.event_q) && DAT_O[31:15] == '0;
    endproperty
    a_event_read: assert property (p_event_read) else $error("event read value wrong");

    property p_cal_link;
        (c_sif.summary && !m_q.q8_prev && q_sif.rise_q[QSET_CAL_BIT] && ques_live[QSET_CAL_BIT])
            |=> q_sif.event_q[QSET_CAL_BIT];
    endproperty
    a_cal_link: assert property (p_cal_link) else $error("calibration summary not linked");

    property p_oper;
        o_sif.summary |=> STATUS_BYTE[QSET_SB_OPER];
    endproperty
    a_oper: assert property (p_oper) else $error("operation summary missing");

    property p_ack_one;
        ACK_O |=> !ACK_O;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

    property p_temp_rise;
        ($rose(ques_live[QSET_TEMP_BIT]) && q_sif.rise_q[QSET_TEMP_BIT])
            |=> q_sif.event_q[QSET_TEMP_BIT];
    endproperty
    a_temp_rise: assert property (p_temp_rise) else $error("temperature rise not latched");

    property p_temp_fall;
        ($fell(ques_live[QSET_TEMP_BIT]) && q_sif.fall_q[QSET_TEMP_BIT] && q_sif.en_q[QSET_TEMP_BIT]
            && !q_sif.wr_en && !q_sif.preset) |-> ##2 STATUS_BYTE[QSET_SB_QUES];
    endproperty
    a_temp_fall: assert property (p_temp_fall) else $error("temperature clear not reported");

    property p_align;
        (c_sif.event_q[QSET_ALIGN_BIT] && c_sif.en_q[QSET_ALIGN_BIT]) |-> ques_live[QSET_CAL_BIT];
    endproperty
    a_align: assert property (p_align) else $error("alignment flag not summarised");

    property p_cal_off;
        (c_sif.event_q & c_sif.en_q) == QSET_ZERO
            |-> !ques_live[QSET_CAL_BIT];
    endproperty
    a_cal_off: assert property (p_cal_off) else $error("calibration summary without event");

    property p_ques_live;
        (rd && grp == QSET_G_QUES && fld == QSET_F_COND)
            |=> DAT_O[QSET_W-1:0] == $past(ques_live);
    endproperty
    a_ques_live: assert property (p_ques_live) else $error("questionable condition not live");

    property p_sb_ques;
        q_sif.summary |=> STATUS_BYTE[QSET_SB_QUES];
    endproperty
    a_sb_ques: assert property (p_sb_ques) else $error("questionable summary missing");

    property p_sb_rest;
        (STATUS_BYTE & ~SB_USED) == '0;
    endproperty
    a_sb_rest: assert property (p_sb_rest) else $error("unused status bit set");

    property p_event_keep;
        o_sif.preset |=> (o_sif.event_q & $past(o_sif.event_q)) == $past(o_sif.event_q);
    endproperty
    a_event_keep: assert property (p_event_keep) else $error("preset touched events");

    property p_mask_write;
        (q_sif.wr_en && q_sif.wsel == 2'h3)
            |=> q_sif.en_q == $past(DAT_I[QSET_W-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("enable write lost");

    property p_lane_keep;
        (q_sif.wr_fall && q_sif.wsel == 2'h1)
            |=> q_sif.fall_q[QSET_W-1:QSET_LO_MSB+1] == $past(q_sif.fall_q[QSET_W-1:QSET_LO_MSB+1]);
    endproperty
    a_lane_keep: assert property (p_lane_keep) else $error("unselected lane written");

    property p_unmapped;
        (rd && grp == QSET_G_MISC && fld != QSET_F_STB) |=> DAT_O == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_ack_take;
        req |=> ACK_O;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("request not acknowledged");

    property p_oper_off;
        (o_sif.event_q & o_sif.en_q) == QSET_ZERO
            |=> !STATUS_BYTE[QSET_SB_OPER];
    endproperty
    a_oper_off: assert property (p_oper_off) else $error("operation summary without event");

    property p_ques_clear;
        (q_sif.rd_clr && $stable(ques_live))
            |=> q_sif.event_q == QSET_ZERO;
    endproperty
    a_ques_clear: assert property (p_ques_clear) else $error("event read did not clear");

    property p_cal_clear;
        (c_sif.rd_clr && $stable(cal_live))
            |=> c_sif.event_q == QSET_ZERO;
    endproperty
    a_cal_clear: assert property (p_cal_clear) else $error("calibration read did not clear");

    c_align: cover property (c_sif.event_q[QSET_ALIGN_BIT] && c_sif.en_q[QSET_ALIGN_BIT]);
    c_sb3:   cover property (STATUS_BYTE[QSET_SB_QUES]);
    c_clear: cover property (q_sif.rd_clr && q_sif.event_q != QSET_ZERO);
endmodule

// ---- verif/qset_tb.sv ----
// Self-checking bench for the questionable status event tree
`timescale 1ns/1ps
module testbench;
    import qset_pkg::*;
    logic                  mclk;
    logic                  reset_n;
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic [QSET_AW-1:0]    adr;
    logic [3:0]            sel;
    logic [QSET_DW-1:0]    dat_w;
    logic [QSET_DW-1:0]    dat_r;
    logic                  ack;
    logic [QSET_W-1:0]     ques_cond;
    logic [QSET_W-1:0]     cal_cond;
    logic [QSET_W-1:0]     oper_cond;
    logic [QSET_STB_W-1:0] status_byte;
    logic [QSET_DW-1:0]    rd;
    logic [QSET_W-1:0]     r;
    logic [QSET_W-1:0]     c;
    logic [3:0]            lanes;
    integer                seed;
    int                    n_fail;
    int                    samples_checked;
    int                    cycles;

    qset_top dut (
        .MCLK        (mclk),
        .RESET_N     (reset_n),
        .CYC_I       (cyc),
        .STB_I       (stb),
        .WE_I        (we),
        .ADR_I       (adr),
        .SEL_I       (sel),
        .DAT_I       (dat_w),
        .DAT_O       (dat_r),
        .ACK_O       (ack),
        .QUES_COND   (ques_cond),
        .CAL_COND    (cal_cond),
        .OPER_COND   (oper_cond),
        .STATUS_BYTE (status_byte)
    );

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= lanes;
        dat_w <= d;
        @(posedge mclk);
        while (ack !== 1'b1)
            @(posedge mclk);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [14:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, {17'h0, d}, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [14:0] exp);
        wb_cycle(1'b0, a, 32'h0, rd);
        check(rd, {17'h0, exp});
    endtask

    task automatic pins(input logic [14:0] q, input logic [14:0] k, input logic [14:0] o);
        @(posedge mclk);
        ques_cond <= q;
        cal_cond  <= k;
        oper_cond <= o;
        repeat (10) @(posedge mclk);
    endtask

    function automatic logic [14:0] rnd_cond(input logic [31:0] v);
        return v[14:0] & 15'h7EFF;
    endfunction

    // Status byte expected from the two summaries
    function automatic logic [31:0] sb_exp(input logic ques, input logic oper);
        sb_exp = '0;
        sb_exp[QSET_SB_QUES] = ques;
        sb_exp[QSET_SB_OPER] = oper;
    endfunction

    initial
    begin
        seed = 32'h58CBA250;
        reset_n = 1'b0;
        {cyc, stb, we, adr, sel, dat_w} = '0;
        {ques_cond, cal_cond, oper_cond} = '0;
        {n_fail, samples_checked, cycles} = '0;
        lanes = 4'hF;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        // Reset values of masks and filters
        for (logic [2:0] g = 3'h0; g < 3'h3; g++)
        begin
            rc({g, QSET_F_RISE}, QSET_RISE_RST);
            rc({g, QSET_F_FALL}, QSET_FALL_RST);
            rc({g, QSET_F_EN}, QSET_EN_RST);
        end
        rc(8'h7C, QSET_ZERO);
        check({24'h0, status_byte}, 32'h0);
        $display("test reset done");
        // Live conditions, random values
        for (int i = 0; i < 4; i++)
        begin
            r = rnd_cond($random(seed));
            c = 15'($random(seed));
            pins(r, c, 15'h0);
            rc({QSET_G_QUES, QSET_F_COND}, r);
            rc({QSET_G_CAL, QSET_F_COND}, c);
            check({24'h0, status_byte}, 32'h0);
        end
        pins(15'h0, 15'h0, 15'h0);
        rc({QSET_G_QUES, QSET_F_COND}, QSET_ZERO);
        for (logic [2:0] g = 3'h0; g < 3'h3; g++)
            wb_cycle(1'b0, {g, QSET_F_EVENT}, 32'h0, rd);
        $display("test condition done");
        // No filter bit, no event
        wr({QSET_G_QUES, QSET_F_RISE}, 15'h0);
        pins(15'h0010, 15'h0, 15'h0);
        pins(15'h0, 15'h0, 15'h0);
        rc({QSET_G_QUES, QSET_F_EVENT}, QSET_ZERO);
        // Rising temperature summary reaches status byte
        wr({QSET_G_QUES, QSET_F_RISE}, 15'h0010);
        wr({QSET_G_QUES, QSET_F_EN}, 15'h0010);
        pins(15'h0010, 15'h0, 15'h0);
        repeat (6) @(posedge mclk);
        check({24'h0, status_byte}, sb_exp(1'b1, 1'b0));
        rc({QSET_G_QUES, QSET_F_EVENT}, 15'h0010);
        repeat (3) @(posedge mclk);
        check({24'h0, status_byte}, 32'h0);
        rc({QSET_G_QUES, QSET_F_EVENT}, QSET_ZERO);
        // Falling temperature summary
        wr({QSET_G_QUES, QSET_F_RISE}, 15'h0);
        wr({QSET_G_QUES, QSET_F_FALL}, 15'h0010);
        pins(15'h0, 15'h0, 15'h0);
        check({24'h0, status_byte}, sb_exp(1'b1, 1'b0));
        rc({QSET_G_QUES, QSET_F_EVENT}, 15'h0010);
        $display("test transition done");
        // Multi-bit events read as one weighted value
        wr({QSET_G_QUES, QSET_F_RISE}, 15'h7FFF);
        wr({QSET_G_QUES, QSET_F_FALL}, 15'h0);
        wr({QSET_G_QUES, QSET_F_EN}, 15'h0);
        rc({QSET_G_QUES, QSET_F_RISE}, 15'h7FFF);
        for (int i = 0; i < 3; i++)
        begin
            r = rnd_cond($random(seed));
            pins(r, 15'h0, 15'h0);
            rc({QSET_G_QUES, QSET_F_EVENT}, r);
            pins(15'h0, 15'h0, 15'h0);
            rc({QSET_G_QUES, QSET_F_EVENT}, QSET_ZERO);
        end
        $display("test weight done");
        // Alignment-needed flag through calibration summary
        wr({QSET_G_CAL, QSET_F_EN}, 15'h4000);
        wr({QSET_G_QUES, QSET_F_EN}, 15'h0100);
        pins(15'h0, 15'h4000, 15'h0);
        rc({QSET_G_QUES, QSET_F_COND}, 15'h0100);
        check({24'h0, status_byte}, sb_exp(1'b1, 1'b0));
        rc({QSET_G_QUES, QSET_F_EVENT}, 15'h0100);
        rc({QSET_G_CAL, QSET_F_EVENT}, 15'h4000);
        repeat (3) @(posedge mclk);
        rc({QSET_G_QUES, QSET_F_COND}, QSET_ZERO);
        $display("test calibration done");
        // Operation start reported in status byte
        wr({QSET_G_OPER, QSET_F_RISE}, 15'h0001);
        wr({QSET_G_OPER, QSET_F_EN}, 15'h0001);
        pins(15'h0, 15'h4000, 15'h0001);
        check({24'h0, status_byte}, sb_exp(1'b0, 1'b1));
        rc({QSET_G_MISC, QSET_F_STB}, 15'h0080);
        // Preset restores masks and keeps events
        wr({QSET_G_QUES, QSET_F_FALL}, 15'h7FFF);
        rc({QSET_G_QUES, QSET_F_FALL}, 15'h7FFF);
        // Low lane only: upper bits of the filter must stay
        lanes = 4'h1;
        wr({QSET_G_QUES, QSET_F_FALL}, 15'h0012);
        lanes = 4'hF;
        rc({QSET_G_QUES, QSET_F_FALL}, 15'h7F12);
        wr({QSET_G_MISC, QSET_F_PRESET}, 15'h0001);
        rc({QSET_G_QUES, QSET_F_FALL}, QSET_FALL_RST);
        rc({QSET_G_OPER, QSET_F_RISE}, QSET_RISE_RST);
        rc({QSET_G_CAL, QSET_F_EN}, QSET_EN_RST);
        rc({QSET_G_OPER, QSET_F_EN}, QSET_EN_RST);
        repeat (2) @(posedge mclk);
        check({24'h0, status_byte}, 32'h0);
        rc({QSET_G_OPER, QSET_F_EVENT}, 15'h0001);
        $display("test preset done");
        end_of_test();
    end
endmodule
